/* rtl/watchdog_defines.vh */
// Purpose: constants for the watchdog timeout reset block
// Assumes: 32-bit AXI4-Lite register bus, 18-bit byte address
// Notes: byte address of a register is its index times four
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH

// ======================================
// register indices and bus
`define WD_ADDR_W 18
`define WD_IDX_CFG 16'h0000
`define WD_IDX_CAUSE 16'h0001
`define WD_IDX_STAT 16'h0002
`define WD_IDX_SVC 16'hFFFF
`define WD_RESP_OKAY 2'h0
`define WD_RESP_SLVERR 2'h2

// ======================================
// field positions
`define WD_CFG_DIS 0
`define WD_CFG_RATE 1
`define WD_CFG_STOPEN 2
`define WD_CAUSE_WD 0
`define WD_CAUSE_ILL 1

// ======================================
// reset values
`define WD_CFG_RST 3'h4
`define WD_CAUSE_RST 2'h0

// ======================================
// counter shape and timing counts
`define WD_PRE_W 12
`define WD_CNT_W 6
`define WD_SVC_KEEP 4
`define WD_SHORT_BITS 13
`define WD_PULSE_TICKS 6'h20
`define WD_POR_OSC_TICKS 13'h1000

`endif

/* rtl/watchdog_timeout_reset.v */
// Purpose: watchdog timer that resets the system on overflow
// Assumes: watchdog and oscillator clocks arrive as slow pins
// Notes: cpu events are one-cycle pulses on aclk
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defines.vh"

// Operation
// - 12-bit prescaler feeds 6-bit counter, both step on watchdog clock
// - unserviced, overflow after 262,144 or 8192 ticks causes reset
// - any write to service register clears counter and prescaler bits 11:4
// - timeout drives reset pin low 32 ticks and sets cause flag
// - service register read returns reset vector low byte, no side effect
// - prescaler cleared 4096 oscillator cycles after power-up
// - internal reset clears prescaler and counter
// - reset vector fetch clears prescaler
// - stop mode gates watchdog clock and clears prescaler
// - stop with stop disabled gives illegal opcode reset
// - watchdog keeps counting in wait mode
// - monitor entry with test voltage on irq disables while irq or reset pin stays at test voltage
// - monitor entry on blank vectors disables until next power-on
// - break with test voltage on reset pin disables watchdog
// - watchdog never raises an interrupt request
// - disable bit set means watchdog never resets
// - rate select 1 short, 0 long; every reset clears it
module watchdog_timeout_reset
(
   // clock, reset, enable
   input wire aclk,
   input wire aresetn,
   input wire ce,
   // axi4-lite write address
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [`WD_ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   // axi4-lite write data
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   // axi4-lite write response
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   output wire [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   input wire [`WD_ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   // axi4-lite read data
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   // pins from outside the aclk domain
   input wire watchdog_clock,
   input wire oscillator_clock,
   input wire power_on_n,
   input wire irq_pin_one_at_test_voltage,
   input wire reset_pin_at_test_voltage,
   // cpu events on aclk
   input wire reset_vector_low,
   input wire [7:0] reset_vector_byte,
   input wire vector_fetch,
   input wire internal_reset,
   input wire stop_instr,
   input wire stop_exit,
   input wire wait_mode,
   input wire monitor_entry,
   input wire blank_vectors,
   input wire break_active,
   // reset outputs
   output wire reset_pin_out_n,
   output wire reset_pin_oe_n,
   output wire illegal_opcode_reset
);

// ======================================
// decode helpers
// one-hot select: cfg, cause, stat, svc
function [3:0] reg_sel;
   input [`WD_ADDR_W-1:0] a;
   begin
      reg_sel[0] = (a[`WD_ADDR_W-1:2] == `WD_IDX_CFG);
      reg_sel[1] = (a[`WD_ADDR_W-1:2] == `WD_IDX_CAUSE);
      reg_sel[2] = (a[`WD_ADDR_W-1:2] == `WD_IDX_STAT);
      reg_sel[3] = (a[`WD_ADDR_W-1:2] == `WD_IDX_SVC);
   end
endfunction

// ======================================
// pin synchronisers
wire [4:0] pin_raw;
wire [4:0] pin_sync;
reg [1:0] clk_prev_ff;
assign pin_raw = {reset_pin_at_test_voltage, irq_pin_one_at_test_voltage,
                  power_on_n, oscillator_clock, watchdog_clock};

// two flops per pin; first stage read only by second
genvar gi;
generate
   for (gi = 0; gi < 5; gi = gi + 1)
   begin : g_sync
      // flops kept local so each stage has a single driving process
      reg meta_ff;
      reg safe_ff;
      always @(posedge aclk)
      begin
         if (!aresetn)
         begin
            meta_ff <= 1'b0;
            safe_ff <= 1'b0;
         end
         else if (ce)
         begin
            meta_ff <= pin_raw[gi];
            safe_ff <= meta_ff;
         end
      end
      assign pin_sync[gi] = safe_ff;
   end
endgenerate

// previous synced clock levels for edge detect
always @(posedge aclk)
begin
   if (!aresetn)
      clk_prev_ff <= 2'h0;
   else if (ce)
      clk_prev_ff <= pin_sync[1:0];
end

wire wd_tick = pin_sync[0] & ~clk_prev_ff[0];
wire osc_tick = pin_sync[1] & ~clk_prev_ff[1];
wire por_n_s = pin_sync[2];
wire irq_tv = pin_sync[3];
wire rst_tv = pin_sync[4];

// ======================================
// axi4-lite slave
reg awready_ff;
reg wready_ff;
reg bvalid_ff;
reg [1:0] bresp_ff;
reg arready_ff;
reg rvalid_ff;
reg [31:0] rdata_ff;
reg [1:0] rresp_ff;
reg aw_ok_ff;
reg w_ok_ff;
reg [`WD_ADDR_W-1:0] awaddr_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;

reg [2:0] cfg_ff;
reg [1:0] cause_ff;
reg [`WD_PRE_W-1:0] pre_ff;
reg [`WD_CNT_W-1:0] cnt_ff;
reg pulse_on_ff;
reg stopped_ff;
reg mon_tv_ff;
reg mon_blank_ff;
wire wd_disabled;

// write completes once address and data are both held
wire wr_go = aw_ok_ff & w_ok_ff & ~bvalid_ff;
wire [3:0] wsel = reg_sel(awaddr_ff);
wire [3:0] rsel = reg_sel(s_axi_araddr);
wire svc_wr = wr_go & wsel[3]; // any data, any lanes
wire cfg_wr = wr_go & wsel[0] & wstrb_ff[0];
wire cause_wr = wr_go & wsel[1] & wstrb_ff[0];

// status word shows the live counter state
wire [31:0] stat_word = {10'h000, mon_blank_ff, stopped_ff,
                         wd_disabled, pulse_on_ff, cnt_ff, pre_ff};

// read mux; service address has no read effect
reg [31:0] rd_mux;
always @*
begin
   rd_mux = 32'h0000_0000;
   case (1'b1)
      rsel[0]: rd_mux = {29'h0000_0000, cfg_ff};
      rsel[1]: rd_mux = {30'h0000_0000, cause_ff};
      rsel[2]: rd_mux = stat_word;
      rsel[3]: rd_mux = {24'h00_0000, reset_vector_byte};
      default: rd_mux = 32'h0000_0000;
   endcase
end

// write channel handshakes and response
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= {`WD_ADDR_W{1'b0}};
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `WD_RESP_OKAY;
   end
   else if (ce)
   begin
      if (s_axi_awvalid & awready_ff)
      begin
         aw_ok_ff <= 1'b1;
         awaddr_ff <= s_axi_awaddr;
         awready_ff <= 1'b0;
      end
      if (s_axi_wvalid & wready_ff)
      begin
         w_ok_ff <= 1'b1;
         wdata_ff <= s_axi_wdata;
         wstrb_ff <= s_axi_wstrb;
         wready_ff <= 1'b0;
      end
      if (wr_go)
      begin
         aw_ok_ff <= 1'b0;
         w_ok_ff <= 1'b0;
         bvalid_ff <= 1'b1;
         bresp_ff <= (|wsel) ? `WD_RESP_OKAY : `WD_RESP_SLVERR;
      end
      // reopen only after the response is taken
      if (bvalid_ff & s_axi_bready)
      begin
         bvalid_ff <= 1'b0;
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
      end
   end
end

// read channel, one outstanding read
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `WD_RESP_OKAY;
   end
   else if (ce)
   begin
      if (s_axi_arvalid & arready_ff)
      begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_mux;
         rresp_ff <= (|rsel) ? `WD_RESP_OKAY : `WD_RESP_SLVERR;
      end
      else if (rvalid_ff & s_axi_rready)
      begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end
end

// ======================================
// power-on delay
// counts oscillator edges after power-on release
reg [12:0] por_cnt_ff;
reg por_done_ff;
wire por_clr = ~por_done_ff & (por_cnt_ff == `WD_POR_OSC_TICKS);
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      por_cnt_ff <= 13'h0000;
      por_done_ff <= 1'b0;
   end
   else if (ce)
   begin
      if (!por_n_s)
      begin
         por_cnt_ff <= 13'h0000;
         por_done_ff <= 1'b0;
      end
      else if (por_clr)
         por_done_ff <= 1'b1; // one clear only
      else if (!por_done_ff & osc_tick)
         por_cnt_ff <= por_cnt_ff + 13'h0001;
   end
end

// ======================================
// disable sources
// monitor latches: test voltage hold and blank vectors
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      mon_tv_ff <= 1'b0;
      mon_blank_ff <= 1'b0;
   end
   else if (ce)
   begin
      if (monitor_entry & irq_tv)
         mon_tv_ff <= 1'b1;
      else if (!(irq_tv | rst_tv))
         mon_tv_ff <= 1'b0;
      if (!por_n_s)
         mon_blank_ff <= 1'b0; // only power-on lifts it
      else if (monitor_entry & ~irq_tv & blank_vectors)
         mon_blank_ff <= 1'b1;
   end
end

// any source stops counting and blocks the reset
assign wd_disabled = cfg_ff[`WD_CFG_DIS] | mon_tv_ff | mon_blank_ff
                     | (break_active & rst_tv);

// ======================================
// watchdog core
wire [17:0] chain = {cnt_ff, pre_ff};
// wait mode is deliberately not a term here
wire run = wd_tick & ~wd_disabled & ~stopped_ff & ~pulse_on_ff;
// short rate wraps on low 13 bits, long on all 18
wire at_end = cfg_ff[`WD_CFG_RATE] ?
              (&chain[`WD_SHORT_BITS-1:0]) : (&chain);
wire timeout = run & at_end;
wire stop_ok = stop_instr & cfg_ff[`WD_CFG_STOPEN];
wire stop_bad = stop_instr & ~cfg_ff[`WD_CFG_STOPEN];
wire pre_clr = stop_ok | vector_fetch | por_clr;
reg [5:0] pulse_cnt_ff;
reg rst_out_n_ff;
reg rst_oe_n_ff;
reg ill_ff;

// prescaler and counter, strongest clear first
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      pre_ff <= {`WD_PRE_W{1'b0}};
      cnt_ff <= {`WD_CNT_W{1'b0}};
   end
   else if (ce)
   begin
      if (internal_reset | timeout)
      begin
         pre_ff <= {`WD_PRE_W{1'b0}};
         cnt_ff <= {`WD_CNT_W{1'b0}};
      end
      else if (pre_clr)
         pre_ff <= {`WD_PRE_W{1'b0}};
      else if (svc_wr)
      begin
         // low stages kept, so period varies by up to 15 ticks
         pre_ff <= {{(`WD_PRE_W-`WD_SVC_KEEP){1'b0}},
                    pre_ff[`WD_SVC_KEEP-1:0]};
         cnt_ff <= {`WD_CNT_W{1'b0}};
      end
      else if (run)
      begin
         pre_ff <= pre_ff + 12'h001;
         if (&pre_ff)
            cnt_ff <= cnt_ff + 6'h01;
      end
   end
end

// stop mode gates the watchdog clock until wakeup
always @(posedge aclk)
begin
   if (!aresetn)
      stopped_ff <= 1'b0;
   else if (ce)
   begin
      if (stop_ok)
         stopped_ff <= 1'b1;
      else if (stop_exit | internal_reset | pulse_on_ff)
         stopped_ff <= 1'b0;
   end
end

// configuration; rate cleared by every reset
always @(posedge aclk)
begin
   if (!aresetn)
      cfg_ff <= `WD_CFG_RST;
   else if (ce)
   begin
      if (cfg_wr)
         cfg_ff <= wdata_ff[2:0];
      if (internal_reset | timeout)
         cfg_ff[`WD_CFG_RATE] <= 1'b0;
   end
end

// cause flags: write one clears, a new event wins
always @(posedge aclk)
begin
   if (!aresetn)
      cause_ff <= `WD_CAUSE_RST;
   else if (ce)
   begin
      if (cause_wr)
         cause_ff <= cause_ff & ~wdata_ff[1:0];
      if (timeout)
         cause_ff[`WD_CAUSE_WD] <= 1'b1;
      if (stop_bad)
         cause_ff[`WD_CAUSE_ILL] <= 1'b1;
   end
end

// pulse timer on its own counter, survives the core clear
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      pulse_on_ff <= 1'b0;
      pulse_cnt_ff <= 6'h00;
   end
   else if (ce)
   begin
      if (timeout)
      begin
         pulse_on_ff <= 1'b1;
         pulse_cnt_ff <= 6'h00;
      end
      else if (pulse_on_ff & wd_tick)
      begin
         if (pulse_cnt_ff == `WD_PULSE_TICKS - 6'h01)
            pulse_on_ff <= 1'b0;
         else
            pulse_cnt_ff <= pulse_cnt_ff + 6'h01;
      end
   end
end

// registered reset outputs; no interrupt path exists
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      rst_out_n_ff <= 1'b1;
      rst_oe_n_ff <= 1'b1;
      ill_ff <= 1'b0;
   end
   else if (ce)
   begin
      rst_out_n_ff <= ~(timeout | (pulse_on_ff & ~(wd_tick &
                      (pulse_cnt_ff == `WD_PULSE_TICKS - 6'h01))));
      rst_oe_n_ff <= ~(timeout | (pulse_on_ff & ~(wd_tick &
                     (pulse_cnt_ff == `WD_PULSE_TICKS - 6'h01))));
      ill_ff <= stop_bad;
   end
end

// ======================================
// output wiring
assign s_axi_awready = awready_ff;
assign s_axi_wready = wready_ff;
assign s_axi_bvalid = bvalid_ff;
assign s_axi_bresp = bresp_ff;
assign s_axi_arready = arready_ff;
assign s_axi_rvalid = rvalid_ff;
assign s_axi_rdata = rdata_ff;
assign s_axi_rresp = rresp_ff;
assign reset_pin_out_n = rst_out_n_ff;
assign reset_pin_oe_n = rst_oe_n_ff;
assign illegal_opcode_reset = ill_ff;

endmodule
`default_nettype wire

/* rtl/watchdog_timeout_reset_spare.v */
// Purpose: none
// Assumes: none
// Notes: none

/* bench/wd_props_properties.sv */
// Purpose: port checker for the watchdog block
// Assumes: ce high, watchdog clock period of 4 aclk
// Notes: bound to the top module below
`timescale 1ns/1ps
`default_nettype none
// ====
// checker
module wd_props
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [17:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [17:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   // cpu side
   input wire logic [7:0] reset_vector_byte,
   input wire logic stop_instr,
   input wire logic break_active,
   input wire logic reset_pin_at_test_voltage,
   // reset outputs
   input wire logic reset_pin_out_n,
   input wire logic reset_pin_oe_n,
   input wire logic illegal_opcode_reset
);
   logic [7:0] low_cnt_ff;
   logic [7:0] nxt_low_cnt;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // cycles spent with the pin pulled low
   assign nxt_low_cnt = reset_pin_out_n ? 8'h00 : low_cnt_ff + 8'h01;
   always @(posedge aclk)
      low_cnt_ff <= aresetn ? nxt_low_cnt : 8'h00;
   sequence svc_rd;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 18'h3_fffc;
   endsequence
   sequence svc_ans;
      s_axi_rvalid && s_axi_rresp == 2'h0 && s_axi_rdata == {24'h00_0000, $past(reset_vector_byte)};
   endsequence
   // open drain: enable and level move together
   oe_follows_a: assert property (reset_pin_oe_n == reset_pin_out_n)
      else $error("reset pin enable differs from level");
   pulse_floor_a: assert property ($fell(reset_pin_out_n) |-> !reset_pin_out_n [*8])
      else $error("reset pulse too short");
   // 32 ticks of 4 cycles each
   pulse_length_a: assert property ($rose(reset_pin_out_n) |-> low_cnt_ff >= 8'h7e && low_cnt_ff <= 8'h82)
      else $error("reset pulse length wrong");
   illegal_single_a: assert property (illegal_opcode_reset |=> !illegal_opcode_reset)
      else $error("illegal reset longer than one cycle");
   illegal_cause_a: assert property (illegal_opcode_reset |-> $past(stop_instr))
      else $error("illegal reset without stop");
   break_quiet_a: assert property ((break_active && reset_pin_at_test_voltage) [*5] |-> !$fell(reset_pin_out_n))
      else $error("reset during break at test voltage");
   svc_read_a: assert property (svc_rd |=> svc_ans)
      else $error("service read data wrong");
   svc_write_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr == 18'h3_fffc |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h0)
      else $error("service write not answered");
endmodule
bind watchdog_timeout_reset wd_props chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
   .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .reset_vector_byte, .stop_instr, .break_active,
   .reset_pin_at_test_voltage, .reset_pin_out_n, .reset_pin_oe_n, .illegal_opcode_reset);
`default_nettype wire

/* bench/wd_partner.sv */
// Purpose: slow clocks and system reset logic around the watchdog
// Assumes: reset pin has a pull-up
// Notes: counts watchdog ticks while the pin is low
`timescale 1ns/1ps
`default_nettype none
// ====
// partner
module wd_partner
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // reset pin drive
   input wire logic reset_pin_out_n,
   input wire logic reset_pin_oe_n,
   // slow clocks
   output logic watchdog_clock,
   output logic oscillator_clock,
   // system side
   output logic pin_level,
   output logic internal_reset,
   output logic vector_fetch,
   output logic [7:0] low_ticks
);
   logic [1:0] div_ff;
   logic lvl_ff;
   // released pin floats up through the pull-up
   assign pin_level = reset_pin_oe_n | reset_pin_out_n;
   assign watchdog_clock = div_ff[1];
   assign oscillator_clock = ~div_ff[1];
   assign internal_reset = ~pin_level;
   // vector fetch follows the pin's release, ticks counted while low
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_ff <= 2'h0;
         lvl_ff <= 1'b1;
         vector_fetch <= 1'b0;
         low_ticks <= 8'h00;
      end
      else
      begin
         div_ff <= div_ff + 2'h1;
         lvl_ff <= pin_level;
         vector_fetch <= !lvl_ff && pin_level;
         // first low cycle may already hold a clock rise
         if (lvl_ff && !pin_level)
            low_ticks <= (div_ff == 2'h1) ? 8'h01 : 8'h00;
         else if (!pin_level && div_ff == 2'h1)
            low_ticks <= low_ticks + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Purpose: self-checking bench for the watchdog block
// Assumes: watchdog clock of 4 aclk from the partner
// Notes: short rate keeps the timeout run near 33k cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic aclk = 1'b0, aresetn = 1'b0, power_on_n = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [17:0] s_axi_awaddr = 18'h0_0000, s_axi_araddr = 18'h0_0000;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rq, st0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic watchdog_clock, oscillator_clock, pin_level, internal_reset, vector_fetch;
   logic [7:0] low_ticks, reset_vector_byte = 8'ha5;
   logic irq_pin_one_at_test_voltage = 1'b0, reset_pin_at_test_voltage = 1'b0, blank_vectors = 1'b0;
   logic stop_instr = 1'b0, stop_exit = 1'b0, wait_mode = 1'b0, monitor_entry = 1'b0, break_active = 1'b0;
   logic reset_pin_out_n, reset_pin_oe_n, illegal_opcode_reset;
   int mismatches = 0, checks = 0, n;
   // 100 ns clock
   always #50 aclk = ~aclk;
   watchdog_timeout_reset uut (.aclk, .aresetn, .ce(1'b1), .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .watchdog_clock, .oscillator_clock, .power_on_n,
      .irq_pin_one_at_test_voltage, .reset_pin_at_test_voltage, .reset_vector_low(1'b0), .reset_vector_byte,
      .vector_fetch, .internal_reset, .stop_instr, .stop_exit, .wait_mode, .monitor_entry, .blank_vectors,
      .break_active, .reset_pin_out_n, .reset_pin_oe_n, .illegal_opcode_reset);
   wd_partner far (.aclk, .aresetn, .reset_pin_out_n, .reset_pin_oe_n, .watchdog_clock, .oscillator_clock,
      .pin_level, .internal_reset, .vector_fetch, .low_ticks);
   task automatic end_sim();
      $display("mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic hang(input int k);
      if (k > 40)
      begin
         mismatches++;
         end_sim();
      end
   endtask
   // write: both channels offered together, each released when taken
   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         hang(k++);
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [17:0] a);
      int k;
      k = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         hang(k++);
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rq = s_axi_rdata;
      rr = s_axi_rresp;
   endtask
   // one-cycle event: 0 stop, 1 stop exit, 2 monitor entry
   task automatic pulse(input int w);
      @(posedge aclk);
      stop_instr <= (w == 0);
      stop_exit <= (w == 1);
      monitor_entry <= (w == 2);
      @(posedge aclk);
      stop_instr <= 1'b0;
      stop_exit <= 1'b0;
      monitor_entry <= 1'b0;
   endtask
   // read stat after a settle time for the synced pins
   task automatic stat_bit(input int b, input logic e);
      repeat (8) @(posedge aclk);
      rd(18'h0_0008);
      check(rq[b], e);
   endtask
   // ====
   // scenarios
   task automatic t_regs();
      rd(18'h0_0000);
      check(rq, 32'h0000_0004);
      rd(18'h3_fffc);
      check(rq, 32'h0000_00a5);
      rd(18'h0_0010);
      check(rr, 2'h2);
      check(rq, 32'h0000_0000);
   endtask
   task automatic t_service();
      repeat (200) @(posedge aclk);
      rd(18'h0_0008);
      st0 = rq;
      rd(18'h3_fffc);
      rd(18'h0_0008);
      check(rq[11:0] >= st0[11:0], 1'b1);
      wr(18'h3_fffc, 32'h0000_005a);
      rd(18'h0_0008);
      check(rq[17:4] <= 14'h0001, 1'b1);
   endtask
   task automatic t_modes();
      wait_mode <= 1'b1;
      rd(18'h0_0008);
      st0 = rq;
      repeat (40) @(posedge aclk);
      rd(18'h0_0008);
      check(rq[11:0] != st0[11:0], 1'b1);
      wr(18'h3_fffc, 32'h0000_0000);
      rd(18'h0_0008);
      check(rq[17:4] <= 14'h0001, 1'b1);
      wait_mode <= 1'b0;
      wr(18'h0_0000, 32'h0000_0005);
      rd(18'h0_0008);
      st0 = rq;
      stat_bit(19, 1'b1);
      check(rq[17:0], st0[17:0]);
      wr(18'h0_0000, 32'h0000_0004);
      pulse(0);
      stat_bit(20, 1'b1);
      check(rq[11:0], 12'h000);
      pulse(1);
      wr(18'h0_0000, 32'h0000_0000);
      pulse(0);
      #1 check(illegal_opcode_reset, 1'b1);
      rd(18'h0_0004);
      check(rq[1], 1'b1);
      wr(18'h0_0004, 32'h0000_0002);
      wr(18'h0_0000, 32'h0000_0004);
   endtask
   task automatic t_test_voltage();
      break_active <= 1'b1;
      reset_pin_at_test_voltage <= 1'b1;
      stat_bit(19, 1'b1);
      break_active <= 1'b0;
      irq_pin_one_at_test_voltage <= 1'b1;
      // let the pin clear its synchroniser before entry
      repeat (4) @(posedge aclk);
      pulse(2);
      irq_pin_one_at_test_voltage <= 1'b0;
      stat_bit(19, 1'b1);
      reset_pin_at_test_voltage <= 1'b0;
      stat_bit(19, 1'b0);
      blank_vectors <= 1'b1;
      pulse(2);
      blank_vectors <= 1'b0;
      stat_bit(21, 1'b1);
      stat_bit(19, 1'b1);
   endtask
   task automatic t_power_on();
      power_on_n <= 1'b0;
      repeat (4) @(posedge aclk);
      power_on_n <= 1'b1;
      stat_bit(19, 1'b0);
      repeat (8192) @(posedge aclk);
      wr(18'h3_fffc, 32'h0000_0000);
      repeat (8250) @(posedge aclk);
      rd(18'h0_0008);
      check(rq[11:0] < 12'h100, 1'b1);
   endtask
   task automatic t_timeout();
      wr(18'h0_0000, 32'h0000_0006);
      wr(18'h3_fffc, 32'h0000_00ff);
      n = 0;
      while (pin_level !== 1'b0 && n < 40000)
      begin
         @(posedge aclk);
         n++;
      end
      check(n >= 32690 && n <= 32790, 1'b1);
      if (n == 40000) hang(99);
      n = 0;
      while (pin_level !== 1'b1 && n < 400)
      begin
         @(posedge aclk);
         n++;
      end
      if (n == 400) hang(99);
      check(low_ticks, 8'h20);
      rd(18'h0_0004);
      check(rq, 32'h0000_0001);
      rd(18'h0_0000);
      check(rq, 32'h0000_0004);
      rd(18'h0_0008);
      check(rq[18:12], 7'h00);
   endtask
   // main sequence
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      power_on_n <= 1'b1;
      repeat (4) @(posedge aclk);
      t_regs();
      t_service();
      t_modes();
      t_test_voltage();
      t_power_on();
      t_timeout();
      end_sim();
   end
endmodule
`default_nettype wire
